// *** text_display_control_setup.sv ***
// Control register bank and display control logic of the text display controller.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
module text_display_control_setup
   import crtc_ctl_pkg::*;
#(
   parameter int HALF_LINE_DEF = HALF_LINE_CYC
)
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Definition block words from the fetch engine.
   input  wire logic        defblk_we,
   input  wire logic        defblk_win,
   input  wire logic [2:0]  defblk_idx,
   input  wire logic [15:0] defblk_data,
   // Display events.
   input  wire logic        frame_pulse,
   input  wire logic        row_scrolled,
   input  wire logic        row_loaded,
   input  wire logic [7:0]  row_loaded_num,
   input  wire logic        intack,
   // Character path.
   input  wire logic [7:0]  char_code,
   input  wire logic        char_invisible,
   input  wire logic        attr_cursor_here,
   input  wire logic [7:0]  beam_col,
   input  wire logic [7:0]  beam_row,
   input  wire logic        vary_heights,
   input  wire logic [4:0]  row_row_scan_total,
   // Bus fetch handshake.
   input  wire logic        fetch_want,
   input  wire logic        fetch_ack,
   // Outputs.
   output logic             bus_req_q,
   output logic             irq_q,
   output logic [7:0]       vector_q,
   output logic             vector_valid_q,
   output logic             hsync_q,
   output logic             vsync_q,
   output logic             blank_q,
   output logic             char_show_q,
   output logic             attr_char_q,
   output logic [7:0]       fill_char_q,
   output logic             fill_attr_fetch_q,
   output logic             xy_cursor_hit_q,
   output logic             attr_cursor_hit_q,
   output logic [1:0]       attr_cursor_shape_q,
   output logic [1:0]       pos_cursor_shape_q,
   output logic [4:0]       row_scan_total_q,
   output logic [23:0]      window_rcb_ptr_q,
   output logic             window_scroll_flag_q,
   output logic             scroll_step_q,
   output logic [3:0]       scroll_lines_q,
   output logic [23:0]      page_hard_ptr_q,
   output logic [23:0]      window_hard_ptr_q
);
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
   endfunction : merge

   function automatic logic hit(input logic [31:0] addr);
      hit = (32'(addr[31:2]) < REG_COUNT) && (addr[1:0] == 2'b00);
   endfunction : hit

   logic [15:0] regs_q [REG_COUNT];
   logic [15:0] md_q [7];
   logic [15:0] wd0_q;
   logic [15:0] wd1_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_held_q;
   logic        w_held_q;
   logic        wr_fire;
   logic [4:0]  widx;
   logic [4:0]  ridx;
   logic [15:0] rword;
   logic        de;
   logic        scroll_on;
   logic        blink_vis;
   logic        step_w;
   logic [3:0]  lines_w;
   logic [15:0] hcnt_q;
   logic [15:0] half_line;
   logic [7:0]  bcnt_q;
   burst_state_type burst_q;

   assign de        = regs_q[REG_MODE1][M1_DE];
   assign scroll_on = md_q[4][MD4_SSE];
   assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
   assign widx      = awaddr_q[6:2];
   assign ridx      = s_axi_araddr[6:2];

   // Address and data are caught separately, so either may come first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= 32'h0000_0000;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit(awaddr_q) ? RESP_OKAY : RESP_SLV;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_comb begin
      rword = regs_q[ridx];
      if (32'(ridx) == REG_MODE2) begin
         rword[M2_SIP] = scroll_on;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= hit(s_axi_araddr) ? {16'h0000, rword} : 32'h0000_0000;
            s_axi_rresp  <= hit(s_axi_araddr) ? RESP_OKAY : RESP_SLV;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Host writes come first; hardware updates below override them in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else begin
         if (wr_fire && hit(awaddr_q)) begin
            unique case (32'(widx))
               REG_MODE1: begin
                  regs_q[REG_MODE1] <= s_axi_wdata_de(wdata_q, wstrb_q)
                                       ? merge(regs_q[REG_MODE1], wdata_q, wstrb_q)
                                       : REG_RESET;
               end
               REG_TPS_LO, REG_TPS_HI, REG_TWS_LO, REG_TWS_HI: begin
                  if (scroll_on) begin
                     regs_q[widx] <= merge(regs_q[widx], wdata_q, wstrb_q);
                  end
               end
               default: begin
                  regs_q[widx] <= merge(regs_q[widx], wdata_q, wstrb_q);
               end
            endcase
         end
         if (row_scrolled && scroll_on) begin
            regs_q[REG_TPH_LO] <= regs_q[REG_TPS_LO];
            regs_q[REG_TPH_HI] <= regs_q[REG_TPS_HI];
            regs_q[REG_TWH_LO] <= regs_q[REG_TWS_LO];
            regs_q[REG_TWH_HI] <= regs_q[REG_TWS_HI];
            regs_q[REG_MODE2][M2_IPS] <= 1'b1;
         end
         if (row_loaded && row_loaded_num == regs_q[REG_VIROW][7:0]) begin
            regs_q[REG_MODE2][M2_IPV] <= 1'b1;
         end
         if (intack && irq_q) begin
            if (regs_q[REG_MODE2][M2_IPS] && regs_q[REG_MODE2][M2_IES]) begin
               regs_q[REG_MODE2][M2_IUSS] <= 1'b1;
            end else begin
               regs_q[REG_MODE2][M2_IUSV] <= 1'b1;
            end
         end
      end
   end

   function automatic logic s_axi_wdata_de(input logic [31:0] data, input logic [3:0] strb);
      s_axi_wdata_de = strb[0] && data[M1_DE];
   endfunction : s_axi_wdata_de

   // Definition block words as fetched by the display engine.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 7; i++) begin
            md_q[i] <= REG_RESET;
         end
         wd0_q <= REG_RESET;
         wd1_q <= REG_RESET;
      end else if (defblk_we) begin
         if (!defblk_win && defblk_idx < 3'd7) begin
            md_q[defblk_idx] <= defblk_data;
         end else if (defblk_win && defblk_idx == 3'd0) begin
            wd0_q <= defblk_data;
         end else if (defblk_win && defblk_idx == 3'd1) begin
            wd1_q <= defblk_data;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q          <= 1'b0;
         vector_q       <= 8'h00;
         vector_valid_q <= 1'b0;
      end else begin
         irq_q <= (regs_q[REG_MODE2][M2_IPS] && regs_q[REG_MODE2][M2_IES]
                   && !regs_q[REG_MODE2][M2_IUSS])
               || (regs_q[REG_MODE2][M2_IPV] && regs_q[REG_MODE2][M2_IEV]
                   && !regs_q[REG_MODE2][M2_IUSV]);
         if (intack && irq_q) begin
            vector_q       <= {md_q[5][7:2], scroll_on, md_q[5][0]};
            vector_valid_q <= !regs_q[REG_MODE1][M1_NV];
         end else begin
            vector_valid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_q   <= BURST_IDLE;
         bcnt_q    <= 8'h00;
         bus_req_q <= 1'b0;
      end else begin
         unique case (burst_q)
            BURST_IDLE: begin
               bcnt_q <= 8'h00;
               if (fetch_want && de) begin
                  burst_q   <= BURST_ON;
                  bus_req_q <= 1'b1;
               end
            end
            BURST_ON: begin
               if (fetch_ack) begin
                  bcnt_q <= bcnt_q + 8'h01;
               end
               if (!fetch_want || (fetch_ack && bcnt_q + 8'h01 >= regs_q[REG_BURST][7:0])) begin
                  burst_q   <= BURST_GAP;
                  bus_req_q <= 1'b0;
                  bcnt_q    <= 8'h00;
               end
            end
            BURST_GAP: begin
               bcnt_q <= bcnt_q + 8'h01;
               if (bcnt_q + 8'h01 >= regs_q[REG_BURST][15:8]) begin
                  burst_q <= BURST_IDLE;
               end
            end
         endcase
      end
   end

   assign half_line = (regs_q[REG_TIM0] == 16'h0000) ? 16'(HALF_LINE_DEF) : regs_q[REG_TIM0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hcnt_q  <= 16'h0000;
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         blank_q <= 1'b1;
      end else if (!de) begin
         hcnt_q  <= 16'h0000;
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         blank_q <= 1'b1;
      end else begin
         blank_q <= 1'b0;
         if (hcnt_q + 16'h0001 >= half_line) begin
            hcnt_q  <= 16'h0000;
            hsync_q <= !hsync_q;
         end else begin
            hcnt_q <= hcnt_q + 16'h0001;
         end
      end
   end

   // Character path flags and values taken from the definition blocks and the control registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         char_show_q          <= 1'b0;
         attr_char_q          <= 1'b0;
         fill_char_q          <= 8'h00;
         fill_attr_fetch_q    <= 1'b0;
         xy_cursor_hit_q      <= 1'b0;
         attr_cursor_hit_q    <= 1'b0;
         attr_cursor_shape_q  <= 2'b00;
         pos_cursor_shape_q   <= 2'b00;
         row_scan_total_q     <= 5'h00;
         window_rcb_ptr_q     <= 24'h00_0000;
         window_scroll_flag_q <= 1'b0;
         page_hard_ptr_q      <= 24'h00_0000;
         window_hard_ptr_q    <= 24'h00_0000;
      end else begin
         char_show_q <= !char_invisible || regs_q[REG_MODE1][M1_DH];
         attr_char_q <= (char_code & regs_q[REG_AFLAG][15:8]) == regs_q[REG_AFLAG][7:0];
         fill_char_q <= md_q[3][7:0];
         fill_attr_fetch_q <= md_q[3][MD3_FAT];
         xy_cursor_hit_q <= regs_q[REG_MODE2][M2_CUE]
                            && beam_col == md_q[2][7:0] && beam_row == md_q[2][15:8];
         attr_cursor_hit_q <= attr_cursor_here && (!md_q[4][MD4_ATTR_CURSOR_BLINK_ON] || blink_vis);
         attr_cursor_shape_q <= regs_q[REG_MODE2][M2_ACM +: 2];
         pos_cursor_shape_q  <= regs_q[REG_MODE2][M2_XYCM +: 2];
         row_scan_total_q <= vary_heights ? md_q[6][4:0] : row_row_scan_total;
         window_rcb_ptr_q     <= {wd0_q[7:0], wd1_q};
         window_scroll_flag_q <= wd0_q[WD0_SCW];
         page_hard_ptr_q      <= {regs_q[REG_TPH_HI][7:0], regs_q[REG_TPH_LO]};
         window_hard_ptr_q    <= {regs_q[REG_TWH_HI][7:0], regs_q[REG_TWH_LO]};
      end
   end

   frame_rate_gen u_rate (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .frame_pulse     (frame_pulse),
      .blink_code      (md_q[4][2:0]),
      .duty_75         (md_q[4][MD4_DUTY]),
      .scroll_code     (md_q[4][MD4_SCR +: 4]),
      .blink_visible_q (blink_vis),
      .scroll_step_q   (step_w),
      .scroll_lines_q  (lines_w)
   );

   // Scroll step only leaves the block while scrolling is on.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scroll_step_q  <= 1'b0;
         scroll_lines_q <= 4'h0;
      end else begin
         scroll_step_q  <= step_w && scroll_on;
         scroll_lines_q <= lines_w;
      end
   end
endmodule : text_display_control_setup

// *** crtc_ctl_pkg.sv ***
// Constants shared by the text display control block.
package crtc_ctl_pkg;
   localparam int REG_COUNT   = 22;
   localparam int REG_MODE1   = 0;
   localparam int REG_MODE2   = 1;
   localparam int REG_ATTR_EN = 2;
   localparam int REG_ATTR_RD = 3;
   localparam int REG_TPH_LO  = 4;
   localparam int REG_TPH_HI  = 5;
   localparam int REG_TWH_LO  = 6;
   localparam int REG_TWH_HI  = 7;
   localparam int REG_TPS_LO  = 8;
   localparam int REG_TPS_HI  = 9;
   localparam int REG_TWS_LO  = 10;
   localparam int REG_TWS_HI  = 11;
   localparam int REG_AFLAG   = 12;
   localparam int REG_BURST   = 13;
   localparam int REG_VIROW   = 14;
   localparam int REG_TIM0    = 15;
   // Mode register one fields.
   localparam int M1_DE = 0;
   localparam int M1_DH = 1;
   localparam int M1_NV = 2;
   // Mode register two fields.
   localparam int M2_IPS  = 0;
   localparam int M2_IES  = 1;
   localparam int M2_IUSS = 2;
   localparam int M2_IPV  = 3;
   localparam int M2_IEV  = 4;
   localparam int M2_IUSV = 5;
   localparam int M2_CUE  = 6;
   localparam int M2_SIP  = 8;
   localparam int M2_ACM  = 9;
   localparam int M2_XYCM = 11;
   // Definition block word fields and the vector scroll bit.
   localparam int MD4_DUTY  = 3;
   localparam int MD4_SCR   = 4;
   localparam int MD4_ATTR_CURSOR_BLINK_ON = 8;
   localparam int MD4_SSE   = 15;
   localparam int MD3_FAT   = 15;
   localparam int WD0_SCW   = 15;
   localparam int VEC_SIP   = 1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [1:0]  RESP_OKAY = 2'b00;
   localparam logic [1:0]  RESP_SLV  = 2'b10;
   // Half line period when the first timing register is still zero.
   localparam int CLK_NS       = 100;
   localparam int HALF_LINE_NS = 32000;
   localparam int HALF_LINE_CYC = HALF_LINE_NS / CLK_NS;
   localparam int BLINK_UNIT   = 16;

   typedef enum logic [1:0] {BURST_IDLE, BURST_ON, BURST_GAP} burst_state_type;
endpackage : crtc_ctl_pkg

// *** frame_rate_gen.sv ***
// Per-frame blink phase and smooth scroll step generator.
module frame_rate_gen
   import crtc_ctl_pkg::*;
(
   // Clock and reset.
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Frame event and rate codes.
   input  wire logic       frame_pulse,
   input  wire logic [2:0] blink_code,
   input  wire logic       duty_75,
   input  wire logic [3:0] scroll_code,
   // Results.
   output logic            blink_visible_q,
   output logic            scroll_step_q,
   output logic [3:0]      scroll_lines_q
);
   logic [7:0] blink_cnt_q;
   logic [7:0] period;
   logic [2:0] slow_cnt_q;

   assign period = 8'((32'(blink_code) + 1) * BLINK_UNIT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_q     <= 8'h00;
         blink_visible_q <= 1'b1;
      end else if (frame_pulse) begin
         blink_cnt_q <= (blink_cnt_q + 8'h01 >= period) ? 8'h00 : blink_cnt_q + 8'h01;
         // duty select
         // A 75% inactive duty keeps the character visible for three quarters of the period.
         blink_visible_q <= duty_75 ? (blink_cnt_q < period - (period >> 2))
                                    : (blink_cnt_q < (period >> 1));
      end
   end

   // Slow codes step one line every n frames; fast codes step n lines per frame.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_cnt_q     <= 3'h0;
         scroll_step_q  <= 1'b0;
         scroll_lines_q <= 4'h0;
      end else begin
         scroll_step_q <= 1'b0;
         if (frame_pulse) begin
            if (scroll_code[3]) begin
               slow_cnt_q <= (slow_cnt_q == scroll_code[2:0]) ? 3'h0 : slow_cnt_q + 3'h1;
               scroll_step_q  <= (slow_cnt_q == scroll_code[2:0]);
               scroll_lines_q <= 4'h1;
            end else begin
               scroll_step_q  <= 1'b1;
               scroll_lines_q <= {1'b0, scroll_code[2:0]} + 4'h1;
            end
         end
      end
   end
endmodule : frame_rate_gen

// *** reg_checker_sva.sv ***
// Port-level assertions for the text display control block.
module reg_checker
   import crtc_ctl_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        intack,
   input wire logic        irq_q,
   input wire logic        vector_valid_q,
   input wire logic        frame_pulse,
   input wire logic        scroll_step_q,
   input wire logic        hsync_q,
   input wire logic        vsync_q,
   input wire logic        blank_q,
   input wire logic        bus_req_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   wr_hold_a: assert property (disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rd_hold_a: assert property (disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   err_data_a: assert property (disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == RESP_SLV |-> s_axi_rdata == 32'h0000_0000)
      else $error("error read returned data");
   vec_cause_a: assert property (disable iff (!aresetn)
      vector_valid_q |-> $past(intack) && $past(irq_q))
      else $error("vector without acknowledge");
   irq_served_a: assert property (disable iff (!aresetn)
      intack && irq_q |-> ##2 !irq_q)
      else $error("request stayed after acknowledge");
   reset_out_a: assert property (
      !aresetn |=> blank_q && !hsync_q && !irq_q && !bus_req_q)
      else $error("outputs not quiet in reset");
   vsync_low_a: assert property (disable iff (!aresetn)
      !vsync_q)
      else $error("vertical sync active");
   step_cause_a: assert property (disable iff (!aresetn)
      scroll_step_q |-> $past(frame_pulse, 2))
      else $error("scroll step without frame");
endmodule : reg_checker

bind text_display_control_setup reg_checker chk_u (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata,
   .intack, .irq_q, .vector_valid_q, .frame_pulse, .scroll_step_q, .hsync_q, .vsync_q,
   .blank_q, .bus_req_q);

// *** bus_partner.sv ***
// Memory side of the shared bus, granting fetch transfers after a set delay.
module bus_partner #(
   parameter int SLOW = 2
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_req_q,
   output logic     fetch_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   // A slow memory keeps the controller waiting so its burst limit is exercised.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 4'h0;
         fetch_ack <= 1'b0;
      end else begin
         cnt_q <= bus_req_q ? cnt_q + 4'h1 : 4'h0;
         fetch_ack <= bus_req_q && cnt_q[1:0] == SLOW[1:0];
      end
   end
endmodule : bus_partner

// *** testbench.sv ***
// Register bus and event tests of the text display control block.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import crtc_ctl_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, defblk_we = 0, defblk_win = 0;
   logic frame_pulse = 0, row_scrolled = 0, row_loaded = 0, intack = 0, char_invisible = 0;
   logic attr_cursor_here = 0, vary_heights = 0, fetch_want = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [2:0]  defblk_idx = 0;
   logic [15:0] defblk_data = 0;
   logic [7:0]  row_loaded_num = 0, char_code = 0, beam_col = 0, beam_row = 0;
   logic [4:0]  row_row_scan_total = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  vector_q, fill_char_q;
   logic [23:0] window_rcb_ptr_q, page_hard_ptr_q, window_hard_ptr_q;
   logic [1:0]  attr_cursor_shape_q, pos_cursor_shape_q, b;
   logic [4:0]  row_scan_total_q;
   logic [3:0]  scroll_lines_q;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetch_ack;
   logic bus_req_q, irq_q, vector_valid_q, hsync_q, char_show_q, fill_attr_fetch_q;
   logic xy_cursor_hit_q, window_scroll_flag_q, h, attr_char_q, attr_cursor_hit_q;
   int error_cnt = 0, num_checks = 0;
   text_display_control_setup #(.HALF_LINE_DEF(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .defblk_we, .defblk_win, .defblk_idx, .defblk_data, .frame_pulse,
      .row_scrolled, .row_loaded, .row_loaded_num, .intack, .char_code, .char_invisible,
      .attr_cursor_here, .beam_col, .beam_row, .vary_heights, .row_row_scan_total, .fetch_want,
      .fetch_ack, .bus_req_q, .irq_q, .vector_q, .vector_valid_q, .hsync_q, .vsync_q(),
      .blank_q(), .char_show_q, .attr_char_q, .fill_char_q, .fill_attr_fetch_q,
      .xy_cursor_hit_q, .attr_cursor_hit_q, .attr_cursor_shape_q,
      .pos_cursor_shape_q, .row_scan_total_q, .window_rcb_ptr_q, .window_scroll_flag_q,
      .scroll_step_q(), .scroll_lines_q, .page_hard_ptr_q, .window_hard_ptr_q);
   bus_partner mem_u (.aclk, .aresetn, .bus_req_q, .fetch_ack);
   always #50 aclk = ~aclk;
   always begin
      repeat (50) @(posedge aclk);
      frame_pulse <= 1;
      @(posedge aclk) frame_pulse <= 0;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input int i, input logic [15:0] d);
      logic a, w;
      a = 1;
      w = 1;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= 4 * i;
      s_axi_wdata <= {16'h0000, d};
      while (a || w) begin
         @(posedge aclk);
         if (a && s_axi_awready) begin a = 0; s_axi_awvalid <= 0; end
         if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
   endtask : wr
   task automatic rd(input int i, input logic [15:0] e, input logic [1:0] r);
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= 4 * i;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk(s_axi_rdata, {16'h0000, e});
      chk(s_axi_rresp, r);
   endtask : rd
   task automatic db(input logic win, input logic [2:0] i, input logic [15:0] d);
      @(posedge aclk) {defblk_we, defblk_win, defblk_idx, defblk_data} <= {1'b1, win, i, d};
      @(posedge aclk) defblk_we <= 0;
   endtask : db
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   initial begin
      #(30000 * 100);
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      fetch_want <= 1;
      for (int i = 0; i < REG_COUNT; i++) rd(i, 16'h0000, RESP_OKAY);
      rd(REG_COUNT, 16'h0000, RESP_SLV);
      wr(REG_MODE1, 16'h0006);
      rd(REG_MODE1, 16'h0000, RESP_OKAY);
      wr(REG_MODE1, 16'h0002);
      rd(REG_MODE1, 16'h0000, RESP_OKAY);
      $display("test reset and soft reset done");
      wr(REG_TIM0, 16'h0004);
      wr(REG_ATTR_EN, 16'h67FF);
      wr(REG_BURST, 16'h0402);
      wr(REG_MODE1, 16'h0001);
      h = 0;
      b = 2'h0;
      // Data is wanted all the time, so only the burst limit can drop the request.
      repeat (40) @(posedge aclk) begin
         if (hsync_q === 1'b1) h = 1;
         if (b[0] && bus_req_q === 1'b0) b[1] = 1;
         if (bus_req_q === 1'b1) b[0] = 1;
      end
      chk(h, 1);
      chk(b, 2'h3);
      $display("test enable done");
      wr(REG_TPS_LO, 16'h1234);
      rd(REG_TPS_LO, 16'h0000, RESP_OKAY);
      db(0, 4, 16'h8000);
      wr(REG_TPS_LO, 16'h1234);
      wr(REG_TWS_LO, 16'h5678);
      rd(REG_TPS_LO, 16'h1234, RESP_OKAY);
      @(posedge aclk) row_scrolled <= 1;
      @(posedge aclk) row_scrolled <= 0;
      repeat (3) @(posedge aclk);
      chk(page_hard_ptr_q, 24'h00_1234);
      chk(window_hard_ptr_q, 24'h00_5678);
      $display("test soft pointers done");
      db(0, 5, 16'h0040);
      wr(REG_VIROW, 16'h0005);
      @(posedge aclk) {row_loaded, row_loaded_num} <= {1'b1, 8'h05};
      @(posedge aclk) row_loaded <= 0;
      repeat (4) @(posedge aclk);
      chk(irq_q, 0);
      // A host write to mode two rewrites the pending bits too, so the row event comes again.
      wr(REG_MODE2, 16'h0010);
      @(posedge aclk) row_loaded <= 1;
      @(posedge aclk) row_loaded <= 0;
      repeat (3) @(posedge aclk);
      chk(irq_q, 1);
      @(posedge aclk) intack <= 1;
      @(posedge aclk) intack <= 0;
      #1 chk(vector_valid_q, 1);
      chk(vector_q, 8'h42);
      repeat (3) @(posedge aclk);
      chk(irq_q, 0);
      $display("test vertical interrupt done");
      db(0, 3, 16'h8020);
      db(0, 2, 16'h0203);
      db(0, 6, 16'h0007);
      db(1, 0, 16'h8001);
      db(1, 1, 16'h2000);
      wr(REG_AFLAG, 16'hF080);
      wr(REG_MODE2, 16'h1640);
      {beam_col, beam_row, char_invisible} <= {8'h03, 8'h02, 1'b1};
      {char_code, attr_cursor_here} <= {8'h85, 1'b1};
      row_row_scan_total <= 5'h0D;
      repeat (3) @(posedge aclk);
      chk(fill_char_q, 8'h20);
      chk(fill_attr_fetch_q, 1);
      chk(window_rcb_ptr_q, 24'h01_2000);
      chk(window_scroll_flag_q, 1);
      chk(xy_cursor_hit_q, 1);
      chk(char_show_q, 0);
      chk(attr_char_q, 1);
      chk(attr_cursor_hit_q, 1);
      chk({attr_cursor_shape_q, pos_cursor_shape_q}, 4'hE);
      chk(row_scan_total_q, 5'h0D);
      chk(scroll_lines_q, 4'h1);
      wr(REG_MODE1, 16'h0003);
      vary_heights <= 1;
      repeat (3) @(posedge aclk);
      chk(char_show_q, 1);
      chk(row_scan_total_q, 5'h07);
      rd(REG_MODE1, 16'h0003, RESP_OKAY);
      $display("test blocks and cursor done");
      end_of_test();
   end
endmodule : testbench
